// ===== hdl/ccpsd_defines.vh
`ifndef CCPSD_DEFINES_VH
`define CCPSD_DEFINES_VH

// register word indices, byte address is index times four
`define CCPSD_IDX_SDG 3'h0
`define CCPSD_IDX_OEC 3'h1
`define CCPSD_IDX_DTC 3'h2
`define CCPSD_IDX_OMP 3'h3
`define CCPSD_IDX_STS 3'h4

// writable bit masks
`define CCPSD_SDG_MASK 16'hD0FF
`define CCPSD_OEC_MASK 16'hBFDF
`define CCPSD_OEC_MASK_AB 16'h83DF
`define CCPSD_DTC_MASK 16'h003F
`define CCPSD_OMP_MASK 16'hF73F

// reset values
`define CCPSD_SDG_RST 16'h0000
`define CCPSD_OEC_RST 16'h0100
`define CCPSD_DTC_RST 16'h0000
`define CCPSD_OMP_RST 16'h0000

// shutdown_gate_control fields
`define CCPSD_SDG_RESTART 15
`define CCPSD_SDG_GATEMODE 14
`define CCPSD_SDG_SWFORCE 12
`define CCPSD_SDG_SRC_HI 7
`define CCPSD_SDG_SRC_LO 0

// output_enable_capture_control fields
`define CCPSD_OEC_SYNC 15
`define CCPSD_OEC_EN_HI 13
`define CCPSD_OEC_EN_LO 8
`define CCPSD_OEC_GSM_HI 7
`define CCPSD_OEC_GSM_LO 6
`define CCPSD_OEC_AUX_HI 4
`define CCPSD_OEC_AUX_LO 3
`define CCPSD_OEC_ICS_HI 2
`define CCPSD_OEC_ICS_LO 0

// dead_time_control field
`define CCPSD_DTC_HI 5
`define CCPSD_DTC_LO 0

// output_mode_polarity_control fields
`define CCPSD_OMP_HOLD 15
`define CCPSD_OMP_OSC_HI 14
`define CCPSD_OMP_OSC_LO 12
`define CCPSD_OMP_OUTM_HI 10
`define CCPSD_OMP_OUTM_LO 8
`define CCPSD_OMP_POLA 5
`define CCPSD_OMP_POLB 4
`define CCPSD_OMP_PSSA_HI 3
`define CCPSD_OMP_PSSA_LO 2
`define CCPSD_OMP_PSSB_HI 1
`define CCPSD_OMP_PSSB_LO 0

// status register fields
`define CCPSD_STS_ARM 10
`define CCPSD_STS_TRIG 7
`define CCPSD_STS_SDFLAG 4
`define CCPSD_STS_CAPDIS 2

// output modes
`define CCPSD_OUTM_SINGLE 3'h0
`define CCPSD_OUTM_PUSHPULL 3'h1
`define CCPSD_OUTM_HALF 3'h2
`define CCPSD_OUTM_BDC_REV 3'h4
`define CCPSD_OUTM_BDC_FWD 3'h5
`define CCPSD_OUTM_SCAN 3'h6

// capture gate modes
`define CCPSD_GSM_LEVEL 2'h0
`define CCPSD_GSM_RISE 2'h1
`define CCPSD_GSM_FALL 2'h2

// auxiliary output selections
`define CCPSD_AUX_OFF 2'h0
`define CCPSD_AUX_ROLL 2'h1
`define CCPSD_AUX_MODE 2'h2
`define CCPSD_AUX_EVENT 2'h3

// shutdown pin states
`define CCPSD_PSS_ACTIVE 2'h3
`define CCPSD_PSS_INACTIVE 2'h2

`define CCPSD_LAST_SCAN 3'h5

`endif

// ===== hdl/ccpsd_dead_time.v
`timescale 1ns/10ps
`default_nettype none
`include "ccpsd_defines.vh"

// splits one signal into a complementary pair, holding both sides off
// for i_dead+1 clock cycles after every change of the input
module ccpsd_dead_time #(
   parameter DT_WIDTH = 6
) (
   input wire i_clock,
   input wire i_reset,
   input wire i_in,
   input wire [DT_WIDTH-1:0] i_dead,
   output reg o_hi,
   output reg o_lo
);

   reg prev;
   reg [DT_WIDTH-1:0] cnt;

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         prev <= 1'b0;
         cnt <= {DT_WIDTH{1'b0}};
         o_hi <= 1'b0;
         o_lo <= 1'b0;
      end else if (i_in != prev) begin
         prev <= i_in;
         cnt <= i_dead;
         // zero count bypasses the gap entirely
         o_hi <= (i_dead == {DT_WIDTH{1'b0}}) & i_in;
         o_lo <= (i_dead == {DT_WIDTH{1'b0}}) & ~i_in;
      end else if (cnt != {DT_WIDTH{1'b0}}) begin
         cnt <= cnt - 1'b1;
         o_hi <= 1'b0;
         o_lo <= 1'b0;
      end else begin
         o_hi <= prev;
         o_lo <= ~prev;
      end
   end

endmodule // ccpsd_dead_time

`default_nettype wire

// ===== hdl/ccpsd_top.v
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "ccpsd_defines.vh"

// What this block does
// - restart enable clears shutdown flag at next period once input gone
// - restart disabled: outputs stay shut down until software clears flag
// - gate mode defers shutdown to next rollover, else immediate
// - software force acts as a shutdown source, deferral still applies
// - eight enable bits each admit one shutdown or gating source
// - output enable sync applies enable changes at next rollover
// - set enable gives pin to module, clear releases it to port
// - only first instance has enables for outputs C through F
// - capture gate modes: level, one-shot rise enable, one-shot fall disable
// - aux select: off, rollover, mode signal, capture/compare event
// - capture source: pin, comparators 1-3, logic cells 1-4
// - dead-time field N of 1..63 inserts N+1 clock cycles, zero disables it
// - trigger mode with hold bit: pins undriven until triggered
// - one-shot extend lengthens trigger by N periods, N+1 total
// - output mode field selects single, push-pull, half-bridge, DC, scan
// - two polarity bits make groups ACE and BDF active-low
// - shutdown state per group: 11 active, 10 inactive, 0x released
// - unimplemented bits read zero, writes ignored
// - flag set holds outputs in shutdown state, clear runs normally
// - writing one to arm bit arms one-shot gate event, reads zero
// - capture disable flag blocks capture events while set
module ccpsd_top #(
   parameter FIRST_INSTANCE = 1,
   parameter NUM_SRC = 8
) (
   input wire i_clock,
   input wire i_reset,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [4:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   input wire [NUM_SRC-1:0] i_shutdown_sources,
   input wire i_capture_input_pin,
   input wire [2:0] i_comparator_output,
   input wire [3:0] i_logic_cell_output,
   input wire i_pwm,
   input wire i_tb_rollover,
   input wire i_period_start,
   input wire i_trigger_operation_enable,
   input wire i_triggered,
   input wire i_one_shot_trigger,
   input wire i_mode_signal,
   input wire i_timer_mode,
   input wire i_capture_event,
   input wire i_compare_event,
   output reg [5:0] o_compare_output_pin,
   output reg [5:0] o_compare_output_pin_oe,
   output reg [5:0] o_pin_owned,
   output reg o_aux_out,
   output reg o_capture_input,
   output reg o_one_shot_active,
   output reg o_shutdown_event_flag
);

   reg [15:0] sdg;
   reg [15:0] oec;
   reg [15:0] dtc;
   reg [15:0] omp;
   reg capture_disable_flag;
   reg gate_armed;
   reg [5:0] oe_live;
   reg [NUM_SRC-1:0] src_m;
   reg [NUM_SRC-1:0] src_s;
   reg [7:0] cap_m;
   reg [7:0] cap_s;
   reg gate_prev;
   reg [2:0] osc_cnt;
   reg pp_phase;
   reg [2:0] scan_idx;
   reg [5:0] act;
   reg [15:0] rd;
   reg [15:0] wlane;
   wire hb_hi;
   wire hb_lo;
   localparam [15:0] OEC_RESET = `CCPSD_OEC_RST;

   wire [15:0] oec_mask = (FIRST_INSTANCE != 0) ?
      `CCPSD_OEC_MASK : `CCPSD_OEC_MASK_AB;
   wire [2:0] idx = i_wb_adr[4:2];
   wire wb_req = i_wb_cyc & i_wb_stb;
   wire wr_now = wb_req & i_wb_we & o_wb_ack;

   wire restart_en = sdg[`CCPSD_SDG_RESTART];
   wire gate_mode = sdg[`CCPSD_SDG_GATEMODE];
   wire sw_force = sdg[`CCPSD_SDG_SWFORCE];
   wire [NUM_SRC-1:0] src_en = sdg[NUM_SRC-1:0];
   wire oe_sync = oec[`CCPSD_OEC_SYNC];
   wire [5:0] oe_bits = oec[`CCPSD_OEC_EN_HI:`CCPSD_OEC_EN_LO];
   wire [1:0] gsm = oec[`CCPSD_OEC_GSM_HI:`CCPSD_OEC_GSM_LO];
   wire [1:0] aux_sel = oec[`CCPSD_OEC_AUX_HI:`CCPSD_OEC_AUX_LO];
   wire [2:0] ics = oec[`CCPSD_OEC_ICS_HI:`CCPSD_OEC_ICS_LO];
   wire [5:0] dead = dtc[`CCPSD_DTC_HI:`CCPSD_DTC_LO];
   wire hold_trig = omp[`CCPSD_OMP_HOLD];
   wire [2:0] osc = omp[`CCPSD_OMP_OSC_HI:`CCPSD_OMP_OSC_LO];
   wire [2:0] outm = omp[`CCPSD_OMP_OUTM_HI:`CCPSD_OMP_OUTM_LO];
   wire pol_a = omp[`CCPSD_OMP_POLA];
   wire pol_b = omp[`CCPSD_OMP_POLB];
   wire [1:0] pss_a = omp[`CCPSD_OMP_PSSA_HI:`CCPSD_OMP_PSSA_LO];
   wire [1:0] pss_b = omp[`CCPSD_OMP_PSSB_HI:`CCPSD_OMP_PSSB_LO];

   // the same request gates captures and shuts the outputs down
   wire sd_req = (|(src_s & src_en)) | sw_force;
   // deferred shutdown waits for the rollover strobe
   wire sd_set = sd_req & (~gate_mode | i_tb_rollover);
   wire sd_auto_clr = restart_en & ~sd_req & i_period_start;
   wire sts_wr = wr_now & (idx == `CCPSD_IDX_STS);
   wire sw_clr_flag = sts_wr & i_wb_sel[0] &
      ~i_wb_dat[`CCPSD_STS_SDFLAG];
   wire sw_clr_cap = sts_wr & i_wb_sel[0] & ~i_wb_dat[`CCPSD_STS_CAPDIS];
   wire sw_arm = sts_wr & i_wb_sel[1] & i_wb_dat[`CCPSD_STS_ARM];
   wire gate_rise = sd_req & ~gate_prev;
   wire gate_fall = ~sd_req & gate_prev;
   // outputs are held off only while a trigger is still awaited
   wire held = i_trigger_operation_enable & hold_trig & ~i_triggered;

   // all asynchronous inputs pass two flops before use
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         src_m <= {NUM_SRC{1'b0}};
         src_s <= {NUM_SRC{1'b0}};
         cap_m <= 8'h00;
         cap_s <= 8'h00;
      end else begin
         src_m <= i_shutdown_sources;
         src_s <= src_m;
         cap_m <= {i_logic_cell_output, i_comparator_output,
            i_capture_input_pin};
         cap_s <= cap_m;
      end
   end

   // lane merge for 16-bit registers on the low half of the bus
   always @* begin
      case (idx)
         `CCPSD_IDX_SDG: rd = sdg;
         `CCPSD_IDX_OEC: rd = oec;
         `CCPSD_IDX_DTC: rd = dtc;
         `CCPSD_IDX_OMP: rd = omp;
         default: rd = 16'h0000;
      endcase
      wlane[7:0] = i_wb_sel[0] ? i_wb_dat[7:0] : rd[7:0];
      wlane[15:8] = i_wb_sel[1] ? i_wb_dat[15:8] : rd[15:8];
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
         sdg <= `CCPSD_SDG_RST;
         oec <= `CCPSD_OEC_RST;
         dtc <= `CCPSD_DTC_RST;
         omp <= `CCPSD_OMP_RST;
      end else begin
         o_wb_ack <= wb_req & ~o_wb_ack;
         o_wb_dat <= 32'h0000_0000;
         if (wb_req & ~o_wb_ack & ~i_wb_we) begin
            if (idx == `CCPSD_IDX_STS) begin
               // the arm bit always reads back as zero
               o_wb_dat[`CCPSD_STS_TRIG] <= i_triggered;
               o_wb_dat[`CCPSD_STS_SDFLAG] <= o_shutdown_event_flag;
               o_wb_dat[`CCPSD_STS_CAPDIS] <= capture_disable_flag;
            end else begin
               o_wb_dat[15:0] <= rd;
            end
         end
         if (wr_now) begin
            case (idx)
               `CCPSD_IDX_SDG: sdg <= wlane & `CCPSD_SDG_MASK;
               `CCPSD_IDX_OEC: oec <= wlane & oec_mask;
               `CCPSD_IDX_DTC: dtc <= wlane & `CCPSD_DTC_MASK;
               `CCPSD_IDX_OMP: omp <= wlane & `CCPSD_OMP_MASK;
               default: sdg <= sdg;
            endcase
         end
      end
   end

   // shutdown event flag: a set (request, at rollover in gate mode) wins over any clear
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_shutdown_event_flag <= 1'b0;
      end else if (sd_set) begin
         o_shutdown_event_flag <= 1'b1;
      end else if (sd_auto_clr | sw_clr_flag) begin
         o_shutdown_event_flag <= 1'b0;
      end
   end

   // capture gating from the shared gate source
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         capture_disable_flag <= 1'b0;
         gate_armed <= 1'b0;
         gate_prev <= 1'b0;
      end else begin
         gate_prev <= sd_req;
         case (gsm)
            `CCPSD_GSM_LEVEL: begin
               capture_disable_flag <= ~sd_req;
               gate_armed <= 1'b0;
            end
            `CCPSD_GSM_RISE: begin
               if (gate_armed & gate_rise) begin
                  capture_disable_flag <= 1'b0;
                  gate_armed <= 1'b0;
               end else begin
                  if (sw_clr_cap) capture_disable_flag <= 1'b0;
                  if (sw_arm) gate_armed <= 1'b1;
               end
            end
            `CCPSD_GSM_FALL: begin
               if (gate_armed & gate_fall) begin
                  capture_disable_flag <= 1'b1;
                  gate_armed <= 1'b0;
               end else begin
                  if (sw_clr_cap) capture_disable_flag <= 1'b0;
                  if (sw_arm) gate_armed <= 1'b1;
               end
            end
            default: begin
               // reserved gate mode leaves the flag alone
               gate_armed <= 1'b0;
            end
         endcase
      end
   end

   // enables, one-shot length, push-pull phase and scan position
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         oe_live <= OEC_RESET[`CCPSD_OEC_EN_HI:`CCPSD_OEC_EN_LO];
         osc_cnt <= 3'h0;
         o_one_shot_active <= 1'b0;
         pp_phase <= 1'b0;
         scan_idx <= 3'h0;
      end else begin
         if (~oe_sync | i_tb_rollover) begin
            oe_live <= oe_bits;
         end
         if (i_one_shot_trigger) begin
            o_one_shot_active <= 1'b1;
            osc_cnt <= osc;
         end else if (o_one_shot_active & i_tb_rollover) begin
            if (osc_cnt == 3'h0) begin
               o_one_shot_active <= 1'b0;
            end else begin
               osc_cnt <= osc_cnt - 1'b1;
            end
         end
         if (i_tb_rollover) begin
            pp_phase <= ~pp_phase;
            scan_idx <= (scan_idx == `CCPSD_LAST_SCAN) ? 3'h0 :
               scan_idx + 1'b1;
         end
      end
   end

   ccpsd_dead_time #(
      .DT_WIDTH(6)
   ) u_dead (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_in(i_pwm),
      .i_dead((outm == `CCPSD_OUTM_HALF) ? dead : 6'h00),
      .o_hi(hb_hi),
      .o_lo(hb_lo)
   );

   // active levels per pin before polarity, a=0 b=1 c=2 d=3 e=4 f=5
   always @* begin
      act = 6'h00;
      case (outm)
         `CCPSD_OUTM_SINGLE: act = {6{i_pwm}};
         `CCPSD_OUTM_PUSHPULL: begin
            act[0] = i_pwm & ~pp_phase;
            act[1] = i_pwm & pp_phase;
         end
         `CCPSD_OUTM_HALF: begin
            act[0] = hb_hi;
            act[1] = hb_lo;
         end
         `CCPSD_OUTM_BDC_REV: begin
            act[2] = 1'b1;
            act[1] = i_pwm;
         end
         `CCPSD_OUTM_BDC_FWD: begin
            act[0] = 1'b1;
            act[3] = i_pwm;
         end
         `CCPSD_OUTM_SCAN: act = {5'h00, i_pwm} << scan_idx;
         default: act = 6'h00;
      endcase
   end

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_pin
         wire pol = (g % 2 == 0) ? pol_a : pol_b;
         wire [1:0] pss = (g % 2 == 0) ? pss_a : pss_b;
         always @(posedge i_clock or posedge i_reset) begin
            if (i_reset) begin
               o_pin_owned[g] <= 1'b0;
               o_compare_output_pin[g] <= 1'b0;
               o_compare_output_pin_oe[g] <= 1'b0;
            end else begin
               o_pin_owned[g] <= oe_live[g];
               if (~oe_live[g]) begin
                  // released pin: port logic owns it
                  o_compare_output_pin[g] <= 1'b0;
                  o_compare_output_pin_oe[g] <= 1'b0;
               end else if (o_shutdown_event_flag) begin
                  o_compare_output_pin[g] <=
                     (pss == `CCPSD_PSS_ACTIVE) ^ pol;
                  o_compare_output_pin_oe[g] <= pss[1];
               end else if (held) begin
                  o_compare_output_pin[g] <= pol;
                  o_compare_output_pin_oe[g] <= 1'b0;
               end else begin
                  o_compare_output_pin[g] <= act[g] ^ pol;
                  o_compare_output_pin_oe[g] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_aux_out <= 1'b0;
         o_capture_input <= 1'b0;
      end else begin
         case (aux_sel)
            `CCPSD_AUX_OFF: o_aux_out <= 1'b0;
            `CCPSD_AUX_ROLL: o_aux_out <= i_tb_rollover;
            `CCPSD_AUX_MODE: o_aux_out <= i_mode_signal;
            `CCPSD_AUX_EVENT: o_aux_out <= ~i_timer_mode &
               (i_capture_event | i_compare_event);
            default: o_aux_out <= 1'b0;
         endcase
         // a blocked source reads low so no edge reaches capture
         o_capture_input <= cap_s[ics] & ~capture_disable_flag;
      end
   end

endmodule // ccpsd_top

`default_nettype wire

// ===== bench/ccpsd_power_stage.sv
`timescale 1ns/10ps
`default_nettype none
// load side of the compare pins: what the power stage actually sees
module ccpsd_power_stage (
   input wire logic i_clock,
   input wire logic [5:0] i_pin,
   input wire logic [5:0] i_pin_oe,
   output wire logic [5:0] o_level
);
   logic [5:0] last = 6'h00;
   // a released pin floats; show the inverse of the last driven level so
   // a stale value never passes for a driven one
   always @(posedge i_clock) begin
      last <= (i_pin_oe & i_pin) | (~i_pin_oe & last);
   end
   assign o_level = (i_pin_oe & i_pin) | (~i_pin_oe & ~last);
endmodule // ccpsd_power_stage
`default_nettype wire

// ===== bench/ccpsd_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ccpsd_checker #(
   parameter FIRST_INSTANCE = 1,
   parameter NUM_SRC = 8
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [4:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [NUM_SRC-1:0] i_shutdown_sources,
   input wire logic i_tb_rollover,
   input wire logic i_period_start,
   input wire logic i_trigger_operation_enable,
   input wire logic i_triggered,
   input wire logic i_one_shot_trigger,
   input wire logic [5:0] o_compare_output_pin,
   input wire logic [5:0] o_compare_output_pin_oe,
   input wire logic [5:0] o_pin_owned,
   input wire logic o_aux_out,
   input wire logic o_one_shot_active,
   input wire logic o_shutdown_event_flag
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   reg [15:0] sdg;
   reg [15:0] oec;
   reg [15:0] omp;
   wire wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
   // shadows assume both low byte lanes, as the bench always writes
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         sdg <= 16'h0000;
         oec <= 16'h0100;
         omp <= 16'h0000;
      end else if (wr) begin
         if (i_wb_adr[4:2] == 3'h0) sdg <= i_wb_dat[15:0];
         if (i_wb_adr[4:2] == 3'h1) oec <= i_wb_dat[15:0];
         if (i_wb_adr[4:2] == 3'h3) omp <= i_wb_dat[15:0];
      end
   end
   wire req = |(i_shutdown_sources & sdg[NUM_SRC-1:0]) | sdg[12];
   wire aux_off = oec[4:3] == 2'h0;
   wire hold = i_trigger_operation_enable && omp[15] && !i_triggered &&
      !o_shutdown_event_flag;
   ack_once_a: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=>
      o_wb_ack ##1 !o_wb_ack) else $error("ack not a single pulse");
   upper_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
      else $error("upper read bits set");
   unmapped_zero_a: assert property ((o_wb_ack && !i_wb_we &&
      i_wb_adr[4:2] > 3'h4) |-> o_wb_dat == 32'h0)
      else $error("unmapped read not zero");
   sd_cause_a: assert property ($rose(o_shutdown_event_flag) |->
      ($past(req) || $past(req, 2) || $past(req, 3)))
      else $error("flag set without request");
   gate_wait_a: assert property (($rose(o_shutdown_event_flag) &&
      sdg[14]) |-> $past(i_tb_rollover)) else $error("gated flag early");
   sd_clear_a: assert property ($fell(o_shutdown_event_flag) |->
      ($past(i_period_start) && sdg[15]) ||
      $past(wr && i_wb_adr[4:2] == 3'h4)) else $error("flag cleared alone");
   pss_state_a: assert property ((o_shutdown_event_flag &&
      $past(o_shutdown_event_flag) && o_pin_owned[0] && $stable(omp) &&
      $past(o_pin_owned[0])) |-> (o_compare_output_pin_oe[0] == omp[3]) &&
      (!omp[3] || o_compare_output_pin[0] == (omp[2] ^ omp[5])))
      else $error("pin A shutdown state wrong");
   owned_oe_a: assert property (((~o_pin_owned & ~$past(o_pin_owned)) &
      o_compare_output_pin_oe) == 6'h00)
      else $error("released pin driven");
   hold_trig_a: assert property ((hold && $past(hold)) |->
      o_compare_output_pin_oe == 6'h00) else $error("driven before trigger");
   aux_off_a: assert property ((aux_off && $past(aux_off)) |-> !o_aux_out)
      else $error("aux out while off");
   oneshot_start_a: assert property ($rose(o_one_shot_active) |->
      $past(i_one_shot_trigger)) else $error("one-shot without trigger");
   // live enables lag the register by one edge and the owned flag by two
   sync_hold_a: assert property ((oec[15] && !i_tb_rollover) |-> ##2
      $stable(o_pin_owned)) else $error("enables changed off rollover");
endmodule // ccpsd_checker
bind ccpsd_top ccpsd_checker #(.FIRST_INSTANCE(FIRST_INSTANCE),
   .NUM_SRC(NUM_SRC)) chk_u (.*);
`default_nettype wire

// ===== bench/ccp_output_shutdown_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccpsd_defines.vh"
module ccp_output_shutdown_control_bench;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cap_pin = 1'b0, roll = 1'b0;
   logic pstart = 1'b0, trig_en = 1'b0, trigd = 1'b0, ostrig = 1'b0;
   logic mode_sig = 1'b0, tmode = 1'b0, cmp_ev = 1'b0, pwm = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic [7:0] src = 8'h00;
   logic [2:0] cmp = 3'h0;
   logic [3:0] logic_cell_output = 4'h0;
   wire [31:0] rdat;
   wire ack, aux, capin, osact, flag;
   wire [5:0] pin, oe, owned, level;
   int err_count = 0;
   int comparisons = 0;
   always #2 i_clock = ~i_clock;
   ccpsd_top dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_shutdown_sources(src), .i_capture_input_pin(cap_pin),
      .i_comparator_output(cmp), .i_logic_cell_output(logic_cell_output), .i_pwm(pwm),
      .i_tb_rollover(roll), .i_period_start(pstart),
      .i_trigger_operation_enable(trig_en), .i_triggered(trigd),
      .i_one_shot_trigger(ostrig), .i_mode_signal(mode_sig),
      .i_timer_mode(tmode), .i_capture_event(1'b0), .i_compare_event(cmp_ev),
      .o_compare_output_pin(pin), .o_compare_output_pin_oe(oe),
      .o_pin_owned(owned), .o_aux_out(aux), .o_capture_input(capin),
      .o_one_shot_active(osact), .o_shutdown_event_flag(flag));
   ccpsd_power_stage load_u (.i_clock(i_clock), .i_pin(pin), .i_pin_oe(oe),
      .o_level(level));
   task automatic test_done;
      if (err_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // one-cycle strobe: 0 rollover, 1 period start, 2 one-shot trigger
   task automatic pulse(input int which);
      if (which == 0) roll <= 1'b1;
      else if (which == 1) pstart <= 1'b1;
      else ostrig <= 1'b1;
      @(posedge i_clock);
      roll <= 1'b0;
      pstart <= 1'b0;
      ostrig <= 1'b0;
   endtask
   task automatic bus(input logic w, input logic [2:0] idx,
      input logic [15:0] d, output logic [31:0] q);
      @(posedge i_clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, d};
      // only the watchdog ends a wait for the answer
      do begin
         @(posedge i_clock);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [2:0] idx, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask
   task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, idx, 16'h0000, q);
      check("read data", exp, q);
   endtask
   task automatic wait_flag(input logic v);
      int n;
      n = 0;
      while (flag !== v && n < 20) begin
         @(posedge i_clock);
         n++;
      end
      check("shutdown flag", {31'h0, v}, {31'h0, flag});
   endtask
   function automatic logic [31:0] mask(input logic [1:0] idx);
      case (idx)
         2'h0: return `CCPSD_SDG_MASK;
         2'h1: return `CCPSD_OEC_MASK;
         2'h2: return `CCPSD_DTC_MASK;
         default: return `CCPSD_OMP_MASK;
      endcase
   endfunction
   initial begin
      repeat (20000) @(posedge i_clock);
      err_count++;
      test_done;
   end
   initial begin
      logic [31:0] v, e;
      int k, c, n;
      v = $urandom(84);
      tick(4);
      i_reset <= 1'b0;
      rd(3'h0, 32'h0000);
      rd(3'h1, 32'h0100);
      rd(3'h4, 32'h0004);
      k = $urandom_range(7);
      wr(3'h0, 16'(1 << k));
      src <= ~(8'h01 << k);
      tick(8);
      check("flag off", 0, {31'h0, flag});
      src <= 8'hFF;
      wait_flag(1'b1);
      src <= 8'h00;
      tick(6);
      check("flag held", 1, {31'h0, flag});
      wr(3'h4, 16'h0000);
      wait_flag(1'b0);
      wr(3'h1, 16'h3F00);
      for (c = 0; c < 4; c++) begin
         v = $urandom_range(3);
         wr(3'h3, 16'((v << 4) | (c << 2) | c));
         wr(3'h0, 16'h1000);
         wait_flag(1'b1);
         tick(2);
         e = c[1] ? 32'h3F : 32'h00;
         check("oe in shutdown", e, {26'h0, oe});
         e = {26'h0, {3{c[0] ^ v[0], c[0] ^ v[1]}}};
         if (c[1]) check("pins", e, {26'h0, level});
         wr(3'h0, 16'h0000);
         wr(3'h4, 16'h0000);
      end
      wr(3'h0, 16'h5000);
      tick(8);
      check("gated flag", 0, {31'h0, flag});
      pulse(0);
      tick(2);
      check("gated flag", 1, {31'h0, flag});
      wr(3'h0, 16'h8000);
      tick(6);
      check("restart wait", 1, {31'h0, flag});
      pulse(1);
      wait_flag(1'b0);
      wr(3'h1, 16'h8000);
      tick(4);
      check("owned", 32'h3F, {26'h0, owned});
      pulse(0);
      tick(2);
      check("owned", 0, {26'h0, owned});
      check("oe released", 0, {26'h0, oe});
      wr(3'h1, 16'h0300);
      tick(3);
      check("owned", 32'h03, {26'h0, owned});
      wr(3'h1, 16'h3F00);
      wr(3'h3, 16'h8000);
      trig_en <= 1'b1;
      tick(3);
      check("oe held", 0, {26'h0, oe});
      trigd <= 1'b1;
      tick(3);
      check("oe triggered", 32'h3F, {26'h0, oe});
      trig_en <= 1'b0;
      trigd <= 1'b0;
      roll <= 1'b1;
      mode_sig <= 1'b1;
      tmode <= 1'b1;
      cmp_ev <= 1'b1;
      for (c = 0; c < 4; c++) begin
         wr(3'h1, 16'(16'h3F00 | (c << 3)));
         tick(3);
         check("aux", (c == 1 || c == 2), {31'h0, aux});
      end
      roll <= 1'b0;
      wr(3'h0, 16'h1000);
      for (c = 0; c < 8; c++) begin
         wr(3'h1, 16'(c));
         v = $urandom;
         cap_pin <= v[0];
         cmp <= v[3:1];
         logic_cell_output <= v[7:4];
         tick(6);
         check("capture", {31'h0, v[c]}, {31'h0, capin});
      end
      wr(3'h0, 16'h0000);
      tick(4);
      rd(3'h4, 32'h0014);
      check("capture off", 0, {31'h0, capin});
      wr(3'h1, 16'h0040);
      cap_pin <= 1'b1;
      wr(3'h4, 16'h0414);
      wr(3'h0, 16'h1000);
      tick(5);
      rd(3'h4, 32'h0010);
      check("capture on", 1, {31'h0, capin});
      wr(3'h0, 16'h0000);
      wr(3'h4, 16'h0000);
      k = $urandom_range(7);
      wr(3'h3, 16'(k << 12));
      pulse(2);
      tick(1);
      n = 0;
      while (osact === 1'b1 && n < 12) begin
         pulse(0);
         tick(1);
         n++;
      end
      check("one shot periods", k + 1, n);
      wr(3'h1, 16'h3F00);
      k = 1 + $urandom_range(62);
      wr(3'h2, 16'(k));
      wr(3'h3, 16'h0200);
      pwm <= 1'b1;
      // both legs stay off through the gap, then the high leg turns on
      tick(k + 3);
      check("dead gap", 0, {30'h0, pin[1:0]});
      tick(1);
      check("half bridge", 1, {30'h0, pin[1:0]});
      pwm <= 1'b0;
      for (k = 0; k < 8; k++) begin
         v = $urandom;
         wr(k[1:0], v[15:0]);
         rd(k[1:0], v & mask(k[1:0]));
      end
      wr(3'h5, v[15:0]);
      rd(3'h5, 32'h0);
      test_done;
   end
endmodule // ccp_output_shutdown_control_bench
`default_nettype wire
